// ===== bench/aab_exec_props.sv
`timescale 1ns/1ps
`include "aab_params.svh"
module aab_exec_props (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic issue,
   input wire aab_pkg::aab_instr_s instr,
   input wire logic ready,
   input wire aab_pkg::aab_wb_s wb,
   input wire logic [7:0] status_register,
   input wire logic [`AAB_PC_W-1:0] pc
);
   // Request accepted at this edge
   logic tk;
   assign tk = issue && ready;
   // One clock domain, one reset
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   AST_ADD: assert property (
      tk && instr.op == aab_pkg::OP_ADD |=> wb.byte_we && wb.data[7:0] == $past(instr.rd_val) + $past(instr.rr_val))
      else $error("add result wrong");
   AST_WORD: assert property (
      tk && instr.op inside {aab_pkg::OP_WORD_ADD_IMM, aab_pkg::OP_WORD_SUB_IMM} |=> !ready ##1 ready && wb.pair_we)
      else $error("word op timing wrong");
   AST_LOGIC: assert property (
      tk && instr.op inside {aab_pkg::OP_AND, aab_pkg::OP_OR, aab_pkg::OP_XOR} |=> wb.byte_we
      && !status_register[`AAB_SR_V] && status_register[`AAB_SR_C] == $past(status_register[`AAB_SR_C]))
      else $error("logic op flags wrong");
   AST_MUL: assert property (
      tk && instr.op == aab_pkg::OP_MUL_UU |=> !ready ##1 wb.prod_we
      && wb.data == $past(instr.rd_val, 2) * $past(instr.rr_val, 2))
      else $error("product wrong");
   AST_FRAC: assert property (
      tk && instr.op == aab_pkg::OP_FRAC_UU |=> !ready ##1 wb.prod_we
      && wb.data == ($past(instr.rd_val, 2) * $past(instr.rr_val, 2)) << 1)
      else $error("fraction product wrong");
   AST_RELATIVE_CALL: assert property (
      tk && instr.op == aab_pkg::OP_RELATIVE_CALL |=> !ready[*3] ##1 ready
      && pc == $past(pc, 4) + {{10{$past(instr.offset[11], 4)}}, $past(instr.offset, 4)} + `AAB_PC_ONE)
      else $error("relative call target or timing wrong");
   AST_EXTENDED_INDIRECT_JUMP: assert property (
      tk && instr.op == aab_pkg::OP_EXT_INDIRECT_JUMP |=> !ready ##1 ready
      && pc == {$past(instr.extended_indirect_high[5:0], 2), $past(instr.z_ptr, 2)})
      else $error("extended jump wrong");
   AST_CALL: assert property (
      tk && instr.op == aab_pkg::OP_DIRECT_CALL |=> !ready[*4] ##1 ready && pc == $past(instr.target, 5))
      else $error("direct call wrong");
   AST_CMP: assert property (
      tk && instr.op inside {aab_pkg::OP_CMP, aab_pkg::OP_CMP_CARRY} |=> ready && !wb.byte_we && !wb.pair_we)
      else $error("compare wrote a register");
   AST_BRU: assert property (
      tk && instr.op == aab_pkg::OP_BRANCH_CARRY_CLEAR && status_register[`AAB_SR_C] |=> ready
      && pc == $past(pc) + `AAB_PC_ONE && status_register == $past(status_register))
      else $error("untaken branch wrong");
endmodule // aab_exec_props
bind aab_exec aab_exec_props u_props (.sys_clk(sys_clk), .rstn(rstn), .issue(issue), .instr(instr),
   .ready(ready), .wb(wb), .status_register(status_register), .pc(pc));

// ===== bench/testbench.sv
`timescale 1ns/1ps
`include "aab_params.svh"
module testbench;
   logic sys_clk = 1'b0; // Core clock
   logic rstn; // Reset, active low
   logic issue; // Request strobe
   aab_pkg::aab_instr_s instr; // Decoded instruction
   logic ready;
   aab_pkg::aab_wb_s wb;
   logic [7:0] status_register;
   logic [`AAB_PC_W-1:0] pc;
   logic [`AAB_PC_W-1:0] p; // Expected pc
   int num_errors = 0;
   int checks_done = 0;
   aab_exec DUT (.sys_clk(sys_clk), .rstn(rstn), .issue(issue), .instr(instr), .ready(ready), .wb(wb),
      .status_register(status_register), .pc(pc));
   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Issue one instruction, wait n cycles, check write-back, flags and pc
   task automatic go(input aab_pkg::aab_op_e op, input logic [7:0] a, input logic [7:0] b, input logic [2:0] n,
      input logic [2:0] w, input logic [15:0] d, input logic [7:0] s, input logic [`AAB_PC_W-1:0] np);
      @(posedge sys_clk);
      issue <= 1'b1;
      // Register subtract takes its operand from the register; the constant is a decoy
      instr <= '{op, op != aab_pkg::OP_SUB, a, b, (op == aab_pkg::OP_SUB) ? ~b : b, {a, a}, b[5:0], a[2:0], b[0],
         {{4{b[7]}}, b}, {a[5:0], a, b}, {a, b}, a, n == 3'h3};
      @(posedge sys_clk);
      issue <= 1'b0;
      // Busy for all but the last cycle
      repeat (n - 3'h1)
      begin
         #1;
         check(ready, 1'b0);
         @(posedge sys_clk);
      end
      #1;
      check(ready, 1'b1);
      check({wb.byte_we, wb.pair_we, wb.prod_we}, w);
      if (w != 3'h0)
         check(wb.data, d);
      check(status_register, s);
      check(pc, np);
      p = np;
   endtask
   // Reset, then the instruction sequence
   initial
   begin
      rstn = 1'b0;
      issue = 1'b0;
      instr = '0;
      p = '0;
      repeat (10) @(posedge sys_clk);
      check(ready, 1'b1);
      check(status_register, 8'h00);
      check(pc, p);
      rstn <= 1'b1;
      go(aab_pkg::OP_ADD,8'h0F,8'h01,3'h1,3'h4,16'h0010,8'h20,p+22'h1);
      go(aab_pkg::OP_ADD,8'h80,8'h80,3'h1,3'h4,16'h0000,8'h0B,p+22'h1);
      go(aab_pkg::OP_ADD_CARRY,8'h01,8'h01,3'h1,3'h4,16'h0003,8'h00,p+22'h1);
      go(aab_pkg::OP_SUB,8'h00,8'h01,3'h1,3'h4,16'h00FF,8'h25,p+22'h1);
      go(aab_pkg::OP_SUB_CARRY,8'h05,8'h02,3'h1,3'h4,16'h0002,8'h00,p+22'h1);
      go(aab_pkg::OP_AND,8'hF0,8'h0F,3'h1,3'h4,16'h0000,8'h02,p+22'h1);
      go(aab_pkg::OP_OR,8'h00,8'h80,3'h1,3'h4,16'h0080,8'h04,p+22'h1);
      go(aab_pkg::OP_XOR,8'hFF,8'hFF,3'h1,3'h4,16'h0000,8'h02,p+22'h1);
      go(aab_pkg::OP_CLEAR_BITS,8'hFF,8'h0F,3'h1,3'h4,16'h00F0,8'h04,p+22'h1);
      go(aab_pkg::OP_ZERO_MINUS_TEST,8'h80,8'h00,3'h1,3'h4,16'h0080,8'h04,p+22'h1);
      go(aab_pkg::OP_CMP,8'h03,8'h05,3'h1,3'h0,16'h0,8'h25,p+22'h1);
      go(aab_pkg::OP_CMP_CARRY,8'h05,8'h04,3'h1,3'h0,16'h0,8'h00,p+22'h1);
      go(aab_pkg::OP_WORD_ADD_IMM,8'hFF,8'h01,3'h2,3'h2,16'h0000,8'h03,p+22'h1);
      go(aab_pkg::OP_WORD_SUB_IMM,8'h00,8'h01,3'h2,3'h2,16'hFFFF,8'h15,p+22'h1);
      go(aab_pkg::OP_MUL_SS,8'hFF,8'h02,3'h2,3'h1,16'hFFFE,8'h15,p+22'h1);
      go(aab_pkg::OP_MIXED_SIGN_MUL,8'hFF,8'hFF,3'h2,3'h1,16'hFF01,8'h15,p+22'h1);
      go(aab_pkg::OP_FRAC_UU,8'h80,8'h80,3'h2,3'h1,16'h8000,8'h14,p+22'h1);
      go(aab_pkg::OP_FRAC_SS,8'hC0,8'h40,3'h2,3'h1,16'hE000,8'h15,p+22'h1);
      go(aab_pkg::OP_MIXED_FRAC_MUL,8'hC0,8'h80,3'h2,3'h1,16'hC000,8'h15,p+22'h1);
      go(aab_pkg::OP_MUL_UU,8'h00,8'h55,3'h2,3'h1,16'h0000,8'h16,p+22'h1);
      go(aab_pkg::OP_RELATIVE_CALL,8'h00,8'hF0,3'h4,3'h0,16'h0,8'h16,p-22'hF);
      go(aab_pkg::OP_EXT_INDIRECT_JUMP,8'h23,8'h45,3'h2,3'h0,16'h0,8'h16,22'h23_2345);
      go(aab_pkg::OP_INDIRECT_CALL,8'h12,8'h34,3'h4,3'h0,16'h0,8'h16,22'h00_1234);
      go(aab_pkg::OP_EXT_INDIRECT_CALL,8'h01,8'h02,3'h4,3'h0,16'h0,8'h16,22'h01_0102);
      go(aab_pkg::OP_DIRECT_CALL,8'h3F,8'hAA,3'h5,3'h0,16'h0,8'h16,22'h3F_3FAA);
      go(aab_pkg::OP_DIRECT_JUMP,8'h00,8'h10,3'h3,3'h0,16'h0,8'h16,22'h00_0010);
      go(aab_pkg::OP_CMP_SKIP_EQ,8'h07,8'h07,3'h3,3'h0,16'h0,8'h16,p+22'h3);
      go(aab_pkg::OP_SKIP_REG_BIT_CLEAR,8'h03,8'hF7,3'h2,3'h0,16'h0,8'h16,p+22'h2);
      go(aab_pkg::OP_SKIP_REG_BIT_SET,8'h03,8'hF7,3'h1,3'h0,16'h0,8'h16,p+22'h1);
      go(aab_pkg::OP_SKIP_IO_BIT_SET,8'h00,8'h01,3'h3,3'h0,16'h0,8'h16,p+22'h3);
      go(aab_pkg::OP_SKIP_IO_BIT_CLEAR,8'h00,8'h01,3'h1,3'h0,16'h0,8'h16,p+22'h1);
      go(aab_pkg::OP_BRANCH_SR_SET,8'h01,8'h05,3'h2,3'h0,16'h0,8'h16,p+22'h6);
      go(aab_pkg::OP_BRANCH_SR_CLEAR,8'h01,8'h05,3'h1,3'h0,16'h0,8'h16,p+22'h1);
      go(aab_pkg::OP_BRANCH_SIGNED_GE,8'h00,8'h05,3'h1,3'h0,16'h0,8'h16,p+22'h1);
      go(aab_pkg::OP_BRANCH_UNSIGNED_GE,8'h00,8'h7F,3'h2,3'h0,16'h0,8'h16,p+22'h80);
      go(aab_pkg::OP_BRANCH_CARRY_CLEAR,8'h00,8'hFE,3'h2,3'h0,16'h0,8'h16,p-22'h1);
      go(aab_pkg::OP_ADD,8'hFF,8'h01,3'h1,3'h4,16'h0000,8'h33,p+22'h1);
      go(aab_pkg::OP_BRANCH_SIGNED_GE,8'h00,8'h02,3'h2,3'h0,16'h0,8'h33,p+22'h3);
      go(aab_pkg::OP_BRANCH_CARRY_CLEAR,8'h00,8'h05,3'h1,3'h0,16'h0,8'h33,p+22'h1);
      go(aab_pkg::OP_BRANCH_CARRY_SET,8'h00,8'h10,3'h2,3'h0,16'h0,8'h33,p+22'h11);
      go(aab_pkg::OP_BRANCH_LOWER,8'h00,8'h01,3'h2,3'h0,16'h0,8'h33,p+22'h2);
      close_out();
   end
   // Watchdog: the sequence needs well under 2000 cycles
   initial
   begin
      #20000;
      num_errors++;
      close_out();
   end
endmodule // testbench

// ===== core/aab_alu.sv
`timescale 1ns/1ps
`include "aab_params.svh"
module aab_alu (
   input wire aab_pkg::aab_op_e op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic [7:0] sr_in,
   output logic [7:0] res,
   output logic [7:0] sr_out
);
   // Add flags: H, V, N, Z, C
   function automatic logic [7:0] add_fl(input logic [7:0] x, y, r, s);
      logic [7:0] o;
      o = s;
      o[`AAB_SR_H] = (x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]);
      o[`AAB_SR_V] = (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
      o[`AAB_SR_C] = (x[7] & y[7]) | (y[7] & ~r[7]) | (~r[7] & x[7]);
      o[`AAB_SR_N] = r[7];
      o[`AAB_SR_Z] = (r == `AAB_BYTE_ZERO);
      return o;
   endfunction
   // Subtract flags; chained forms keep Z only while zero
   function automatic logic [7:0] sub_fl(input logic [7:0] x, y, r, s, input logic chain);
      logic [7:0] o;
      o = s;
      o[`AAB_SR_H] = (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]);
      o[`AAB_SR_V] = (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]);
      o[`AAB_SR_C] = (~x[7] & y[7]) | (y[7] & r[7]) | (r[7] & ~x[7]);
      o[`AAB_SR_N] = r[7];
      o[`AAB_SR_Z] = (r == `AAB_BYTE_ZERO) & (~chain | s[`AAB_SR_Z]);
      return o;
   endfunction
   // Logic flags: V cleared, N and Z from result
   function automatic logic [7:0] log_fl(input logic [7:0] r, s);
      logic [7:0] o;
      o = s;
      o[`AAB_SR_V] = 1'b0;
      o[`AAB_SR_N] = r[7];
      o[`AAB_SR_Z] = (r == `AAB_BYTE_ZERO);
      return o;
   endfunction
   // Byte result and flag update
   always_comb
   begin
      logic [7:0] cin;
      cin = {7'h00, sr_in[`AAB_SR_C]};
      res = a;
      sr_out = sr_in;
      case (op)
         aab_pkg::OP_ADD, aab_pkg::OP_ADD_CARRY:
         begin
            res = a + b + ((op == aab_pkg::OP_ADD_CARRY) ? cin : `AAB_BYTE_ZERO);
            sr_out = add_fl(a, b, res, sr_in);
         end
         aab_pkg::OP_SUB, aab_pkg::OP_SUB_CARRY, aab_pkg::OP_CMP, aab_pkg::OP_CMP_CARRY:
         begin
            res = a - b - (((op == aab_pkg::OP_SUB_CARRY) | (op == aab_pkg::OP_CMP_CARRY)) ? cin : `AAB_BYTE_ZERO);
            sr_out = sub_fl(a, b, res, sr_in, (op == aab_pkg::OP_SUB_CARRY) | (op == aab_pkg::OP_CMP_CARRY));
         end
         aab_pkg::OP_AND:
         begin
            res = a & b;
            sr_out = log_fl(res, sr_in);
         end
         aab_pkg::OP_OR:
         begin
            res = a | b;
            sr_out = log_fl(res, sr_in);
         end
         aab_pkg::OP_XOR:
         begin
            res = a ^ b;
            sr_out = log_fl(res, sr_in);
         end
         aab_pkg::OP_CLEAR_BITS:
         begin
            res = a & (`AAB_BYTE_ONES - b);
            sr_out = log_fl(res, sr_in);
         end
         aab_pkg::OP_ZERO_MINUS_TEST:
         begin
            res = a & a;
            sr_out = log_fl(res, sr_in);
         end
         default:
         begin
            res = a;
            sr_out = sr_in;
         end
      endcase
   end
endmodule // aab_alu

// ===== core/aab_exec.sv
`timescale 1ns/1ps
`include "aab_params.svh"
// Overview of operation
// - Add with or without carry, five flags, one cycle
// - Subtract register or constant, five flags, one cycle
// - Word add or subtract immediate, two cycles
// - And, or, xor set Z N V, one cycle
// - Clear bits ands with ones minus constant
// - Zero-minus test ands register with itself
// - Byte multiplies write product pair, two cycles
// - Fractional multiplies shift product left once
// - Relative call loads pc plus offset plus one
// - Extended indirect jump loads high:Z, two cycles
// - Indirect calls load pointer, four cycles
// - Direct call five cycles, direct jump three
// - Compare-skip-equal skips, one to three cycles
// - Compares update flags, store nothing
// - Register bit skips, one to three cycles
// - I/O bit skips, one to three cycles
// - Status bit branch to pc plus offset plus one
// - Signed ge taken when N xor V clear
// - Same-or-higher on carry clear, lower on set
// - Carry branches leave flags untouched
module aab_exec (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic issue,
   input wire aab_pkg::aab_instr_s instr,
   output logic ready,
   output aab_pkg::aab_wb_s wb,
   output logic [7:0] status_register,
   output logic [`AAB_PC_W-1:0] pc
);
   // Sequencer state
   aab_pkg::aab_state_e state;
   aab_pkg::aab_state_e next_state;
   // Cycles still to run
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   // Results held until the last cycle
   logic [`AAB_PC_W-1:0] pend_pc;
   logic [`AAB_PC_W-1:0] next_pend_pc;
   logic [7:0] pend_sr;
   logic [7:0] next_pend_sr;
   aab_pkg::aab_wb_s pend_wb;
   aab_pkg::aab_wb_s next_pend_wb;
   // Next output values
   logic next_ready;
   aab_pkg::aab_wb_s next_wb;
   logic [7:0] next_sr;
   logic [`AAB_PC_W-1:0] next_pc;
   // Outcome of the instruction at the port
   logic [`AAB_PC_W-1:0] ex_pc;
   logic [7:0] ex_sr;
   aab_pkg::aab_wb_s ex_wb;
   logic [2:0] ex_cyc;
   // Skip or branch condition
   logic cond;
   // Second operand: register or constant
   logic [7:0] opnd_b;
   // Byte unit results
   logic [7:0] alu_res;
   logic [7:0] alu_sr;
   // Multiplier results and modes
   logic [15:0] mul_prod;
   logic [7:0] mul_sr;
   logic mul_a_signed;
   logic mul_b_signed;
   logic mul_frac;
   // Word unit result
   logic [15:0] word_res;

   // Relative target: pc plus signed offset plus one
   function automatic logic [`AAB_PC_W-1:0] rel_target(input logic [`AAB_PC_W-1:0] base,
                                                       input logic [11:0] off);
      logic [`AAB_PC_W-1:0] ext;
      ext = {{(`AAB_PC_W-12){off[11]}}, off};
      return base + ext + `AAB_PC_ONE;
   endfunction

   // Skip length follows the size of the skipped instruction
   function automatic logic [`AAB_PC_W-1:0] skip_step(input logic two_word);
      return two_word ? `AAB_PC_THREE : `AAB_PC_TWO;
   endfunction

   // Skip cycles follow the same size
   function automatic logic [2:0] skip_cyc(input logic two_word);
      return two_word ? `AAB_CYC_3 : `AAB_CYC_2;
   endfunction

   // Constant or register operand
   assign opnd_b = instr.use_imm ? instr.imm : instr.rr_val;

   // Byte arithmetic and logic unit
   aab_alu u_alu (
      .op(instr.op),
      .a(instr.rd_val),
      .b(opnd_b),
      .sr_in(status_register),
      .res(alu_res),
      .sr_out(alu_sr)
   );

   // Multiplier mode selection
   always_comb
   begin
      mul_a_signed = 1'b0;
      mul_b_signed = 1'b0;
      mul_frac = 1'b0;
      case (instr.op)
         aab_pkg::OP_MUL_SS:
         begin
            mul_a_signed = 1'b1;
            mul_b_signed = 1'b1;
         end
         aab_pkg::OP_MIXED_SIGN_MUL:
         begin
            mul_a_signed = 1'b1;
         end
         aab_pkg::OP_FRAC_UU:
         begin
            mul_frac = 1'b1;
         end
         aab_pkg::OP_FRAC_SS:
         begin
            mul_a_signed = 1'b1;
            mul_b_signed = 1'b1;
            mul_frac = 1'b1;
         end
         aab_pkg::OP_MIXED_FRAC_MUL:
         begin
            mul_a_signed = 1'b1;
            mul_frac = 1'b1;
         end
         default:
         begin
            mul_frac = 1'b0;
         end
      endcase
   end

   // Eight by eight multiplier
   aab_mult u_mult (
      .a(instr.rd_val),
      .b(instr.rr_val),
      .a_signed(mul_a_signed),
      .b_signed(mul_b_signed),
      .frac(mul_frac),
      .sr_in(status_register),
      .prod(mul_prod),
      .sr_out(mul_sr)
   );

   // Word add or subtract on the high:low pair
   assign word_res = (instr.op == aab_pkg::OP_WORD_SUB_IMM) ?
                     instr.pair_val - {10'h000, instr.word_imm} :
                     instr.pair_val + {10'h000, instr.word_imm};

   // Work out pc, flags, write-back and cycle count
   always_comb
   begin
      ex_pc = pc + `AAB_PC_ONE;
      ex_sr = status_register;
      ex_wb = '0;
      ex_cyc = `AAB_CYC_1;
      cond = 1'b0;
      case (instr.op)
         // Byte operations writing the destination
         aab_pkg::OP_ADD, aab_pkg::OP_ADD_CARRY, aab_pkg::OP_SUB, aab_pkg::OP_SUB_CARRY,
         aab_pkg::OP_AND, aab_pkg::OP_OR, aab_pkg::OP_XOR, aab_pkg::OP_CLEAR_BITS:
         begin
            ex_sr = alu_sr;
            ex_wb.byte_we = 1'b1;
            ex_wb.data = {`AAB_BYTE_ZERO, alu_res};
         end
         // Test writes back the unchanged value
         aab_pkg::OP_ZERO_MINUS_TEST:
         begin
            ex_sr = alu_sr;
            ex_wb.byte_we = 1'b1;
            ex_wb.data = {`AAB_BYTE_ZERO, alu_res};
         end
         // Compares keep the difference private
         aab_pkg::OP_CMP, aab_pkg::OP_CMP_CARRY:
         begin
            ex_sr = alu_sr;
         end
         // Word operations: two cycles, pair written
         aab_pkg::OP_WORD_ADD_IMM, aab_pkg::OP_WORD_SUB_IMM:
         begin
            ex_cyc = `AAB_CYC_2;
            ex_wb.pair_we = 1'b1;
            ex_wb.data = word_res;
            ex_sr[`AAB_SR_N] = word_res[15];
            ex_sr[`AAB_SR_Z] = (word_res == `AAB_WORD_ZERO);
            if (instr.op == aab_pkg::OP_WORD_SUB_IMM)
            begin
               ex_sr[`AAB_SR_V] = instr.pair_val[15] & ~word_res[15];
               ex_sr[`AAB_SR_C] = word_res[15] & ~instr.pair_val[15];
            end
            else
            begin
               ex_sr[`AAB_SR_V] = ~instr.pair_val[15] & word_res[15];
               ex_sr[`AAB_SR_C] = ~word_res[15] & instr.pair_val[15];
            end
            ex_sr[`AAB_SR_S] = ex_sr[`AAB_SR_N] ^ ex_sr[`AAB_SR_V];
         end
         // Multiplies into the product pair
         aab_pkg::OP_MUL_UU, aab_pkg::OP_MUL_SS, aab_pkg::OP_MIXED_SIGN_MUL,
         aab_pkg::OP_FRAC_UU, aab_pkg::OP_FRAC_SS, aab_pkg::OP_MIXED_FRAC_MUL:
         begin
            ex_cyc = `AAB_CYC_2;
            ex_sr = mul_sr;
            ex_wb.prod_we = 1'b1;
            ex_wb.data = mul_prod;
         end
         // Relative call
         aab_pkg::OP_RELATIVE_CALL:
         begin
            ex_pc = rel_target(pc, instr.offset);
            ex_cyc = `AAB_CYC_4;
         end
         // Extended indirect jump
         aab_pkg::OP_EXT_INDIRECT_JUMP:
         begin
            ex_pc = {instr.extended_indirect_high[5:0], instr.z_ptr};
            ex_cyc = `AAB_CYC_2;
         end
         // Plain indirect call through Z
         aab_pkg::OP_INDIRECT_CALL:
         begin
            ex_pc = {6'h00, instr.z_ptr};
            ex_cyc = `AAB_CYC_4;
         end
         // Extended indirect call
         aab_pkg::OP_EXT_INDIRECT_CALL:
         begin
            ex_pc = {instr.extended_indirect_high[5:0], instr.z_ptr};
            ex_cyc = `AAB_CYC_4;
         end
         // Direct call and jump
         aab_pkg::OP_DIRECT_CALL:
         begin
            ex_pc = instr.target;
            ex_cyc = `AAB_CYC_5;
         end
         aab_pkg::OP_DIRECT_JUMP:
         begin
            ex_pc = instr.target;
            ex_cyc = `AAB_CYC_3;
         end
         // Skips: condition picked here, step applied below
         aab_pkg::OP_CMP_SKIP_EQ:
         begin
            cond = (instr.rd_val == instr.rr_val);
         end
         aab_pkg::OP_SKIP_REG_BIT_CLEAR:
         begin
            cond = ~instr.rr_val[instr.bit_sel];
         end
         aab_pkg::OP_SKIP_REG_BIT_SET:
         begin
            cond = instr.rr_val[instr.bit_sel];
         end
         aab_pkg::OP_SKIP_IO_BIT_CLEAR:
         begin
            cond = ~instr.io_bit;
         end
         aab_pkg::OP_SKIP_IO_BIT_SET:
         begin
            cond = instr.io_bit;
         end
         // Branches: condition picked here, target applied below
         aab_pkg::OP_BRANCH_SR_SET:
         begin
            cond = status_register[instr.bit_sel];
         end
         aab_pkg::OP_BRANCH_SR_CLEAR:
         begin
            cond = ~status_register[instr.bit_sel];
         end
         aab_pkg::OP_BRANCH_SIGNED_GE:
         begin
            cond = ~(status_register[`AAB_SR_N] ^ status_register[`AAB_SR_V]);
         end
         aab_pkg::OP_BRANCH_UNSIGNED_GE, aab_pkg::OP_BRANCH_CARRY_CLEAR:
         begin
            cond = ~status_register[`AAB_SR_C];
         end
         aab_pkg::OP_BRANCH_LOWER, aab_pkg::OP_BRANCH_CARRY_SET:
         begin
            cond = status_register[`AAB_SR_C];
         end
         default:
         begin
            cond = 1'b0;
         end
      endcase
      // Skip taken: jump over one or two words
      if (cond && (instr.op >= aab_pkg::OP_CMP_SKIP_EQ) && (instr.op <= aab_pkg::OP_SKIP_IO_BIT_SET))
      begin
         ex_pc = pc + skip_step(instr.next_two_word);
         ex_cyc = skip_cyc(instr.next_two_word);
      end
      // Branch taken: relative target, extra cycle
      if (cond && (instr.op >= aab_pkg::OP_BRANCH_SR_SET))
      begin
         ex_pc = rel_target(pc, instr.offset);
         ex_cyc = `AAB_CYC_2;
      end
   end

   // Sequencer: commit at once or after the remaining cycles
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_pend_pc = pend_pc;
      next_pend_sr = pend_sr;
      next_pend_wb = pend_wb;
      next_ready = ready;
      next_wb = '0;
      next_sr = status_register;
      next_pc = pc;
      case (state)
         aab_pkg::AAB_IDLE:
         begin
            if (issue)
            begin
               if (ex_cyc == `AAB_CYC_1)
               begin
                  // Single cycle: commit on this edge
                  next_pc = ex_pc;
                  next_sr = ex_sr;
                  next_wb = ex_wb;
               end
               else
               begin
                  // Multi cycle: hold results, stall the port
                  next_state = aab_pkg::AAB_WAIT;
                  next_cnt = ex_cyc - `AAB_CYC_1;
                  next_pend_pc = ex_pc;
                  next_pend_sr = ex_sr;
                  next_pend_wb = ex_wb;
                  next_ready = 1'b0;
               end
            end
         end
         aab_pkg::AAB_WAIT:
         begin
            if (cnt == `AAB_CYC_1)
            begin
               // Last cycle: commit and accept again
               next_state = aab_pkg::AAB_IDLE;
               next_pc = pend_pc;
               next_sr = pend_sr;
               next_wb = pend_wb;
               next_ready = 1'b1;
            end
            else
            begin
               next_cnt = cnt - `AAB_CYC_1;
            end
         end
         default:
         begin
            next_state = aab_pkg::AAB_IDLE;
         end
      endcase
   end

   // State and output registers
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= aab_pkg::AAB_IDLE;
         cnt <= 3'h0;
         pend_pc <= `AAB_PC_RST;
         pend_sr <= `AAB_SR_RST;
         pend_wb <= '0;
         ready <= 1'b1;
         wb <= '0;
         status_register <= `AAB_SR_RST;
         pc <= `AAB_PC_RST;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         pend_pc <= next_pend_pc;
         pend_sr <= next_pend_sr;
         pend_wb <= next_pend_wb;
         ready <= next_ready;
         wb <= next_wb;
         status_register <= next_sr;
         pc <= next_pc;
      end
   end
endmodule // aab_exec

// ===== core/aab_mult.sv
`timescale 1ns/1ps
`include "aab_params.svh"
module aab_mult (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic a_signed,
   input wire logic b_signed,
   input wire logic frac,
   input wire logic [7:0] sr_in,
   output logic [15:0] prod,
   output logic [7:0] sr_out
);
   // Extend each operand by one bit so one signed multiplier covers all modes
   logic signed [8:0] ext_a;
   logic signed [8:0] ext_b;
   logic signed [17:0] full;
   assign ext_a = {a_signed & a[7], a};
   assign ext_b = {b_signed & b[7], b};
   assign full = ext_a * ext_b;
   // Carry is bit 15 of the raw product; fractional forms shift left once
   always_comb
   begin
      prod = frac ? {full[14:0], 1'b0} : full[15:0];
      sr_out = sr_in;
      sr_out[`AAB_SR_C] = full[15];
      sr_out[`AAB_SR_Z] = (prod == `AAB_WORD_ZERO);
   end
endmodule // aab_mult

// ===== core/aab_params.svh
`ifndef AAB_PARAMS_SVH
`define AAB_PARAMS_SVH
// Status register bit positions
`define AAB_SR_C 0
`define AAB_SR_Z 1
`define AAB_SR_N 2
`define AAB_SR_V 3
`define AAB_SR_S 4
`define AAB_SR_H 5
// Program counter width and steps
`define AAB_PC_W 22
`define AAB_PC_RST 22'h00_0000
`define AAB_PC_ONE 22'h00_0001
`define AAB_PC_TWO 22'h00_0002
`define AAB_PC_THREE 22'h00_0003
// Status register reset value
`define AAB_SR_RST 8'h00
// Cycle counts per instruction class
`define AAB_CYC_1 3'h1
`define AAB_CYC_2 3'h2
`define AAB_CYC_3 3'h3
`define AAB_CYC_4 3'h4
`define AAB_CYC_5 3'h5
// Byte and word constants
`define AAB_BYTE_ONES 8'hFF
`define AAB_BYTE_ZERO 8'h00
`define AAB_WORD_ZERO 16'h0000
`endif

// ===== core/aab_pkg.sv
`include "aab_params.svh"
package aab_pkg;
   // Operation codes handed over by the decoder
   typedef enum logic [5:0] {
      OP_ADD = 6'b000000, OP_ADD_CARRY = 6'b000001, OP_SUB = 6'b000010,
      OP_SUB_CARRY = 6'b000011, OP_AND = 6'b000100, OP_OR = 6'b000101,
      OP_XOR = 6'b000110, OP_CLEAR_BITS = 6'b000111, OP_ZERO_MINUS_TEST = 6'b001000,
      OP_CMP = 6'b001001, OP_CMP_CARRY = 6'b001010, OP_WORD_ADD_IMM = 6'b001011,
      OP_WORD_SUB_IMM = 6'b001100, OP_MUL_UU = 6'b001101, OP_MUL_SS = 6'b001110,
      OP_MIXED_SIGN_MUL = 6'b001111, OP_FRAC_UU = 6'b010000, OP_FRAC_SS = 6'b010001,
      OP_MIXED_FRAC_MUL = 6'b010010, OP_RELATIVE_CALL = 6'b010011,
      OP_EXT_INDIRECT_JUMP = 6'b010100, OP_INDIRECT_CALL = 6'b010101,
      OP_EXT_INDIRECT_CALL = 6'b010110, OP_DIRECT_CALL = 6'b010111,
      OP_DIRECT_JUMP = 6'b011000, OP_CMP_SKIP_EQ = 6'b011001,
      OP_SKIP_REG_BIT_CLEAR = 6'b011010, OP_SKIP_REG_BIT_SET = 6'b011011,
      OP_SKIP_IO_BIT_CLEAR = 6'b011100, OP_SKIP_IO_BIT_SET = 6'b011101,
      OP_BRANCH_SR_SET = 6'b011110, OP_BRANCH_SR_CLEAR = 6'b011111,
      OP_BRANCH_SIGNED_GE = 6'b100000, OP_BRANCH_UNSIGNED_GE = 6'b100001,
      OP_BRANCH_LOWER = 6'b100010, OP_BRANCH_CARRY_CLEAR = 6'b100011,
      OP_BRANCH_CARRY_SET = 6'b100100
   } aab_op_e;
   // Sequencer states
   typedef enum logic {
      AAB_IDLE = 1'b0,
      AAB_WAIT = 1'b1
   } aab_state_e;
   // Decoded instruction with operand values
   typedef struct packed {
      aab_op_e op;
      logic use_imm;
      logic [7:0] rd_val;
      logic [7:0] rr_val;
      logic [7:0] imm;
      logic [15:0] pair_val;
      logic [5:0] word_imm;
      logic [2:0] bit_sel;
      logic io_bit;
      logic [11:0] offset;
      logic [`AAB_PC_W-1:0] target;
      logic [15:0] z_ptr;
      logic [7:0] extended_indirect_high;
      logic next_two_word;
   } aab_instr_s;
   // Register file write-back
   typedef struct packed {
      logic byte_we;
      logic pair_we;
      logic prod_we;
      logic [15:0] data;
   } aab_wb_s;
endpackage
